// ---- common/cesr_pkg.sv ----
// Constants and types for the CPU exception-state and system-register block.
// Assumes a single CPU clock; the pipeline issues one system-register or event request per cycle.
// Summary of operation
// - Program counter keeps only bits 25..0; upper bits read zero.
// - Carry out of bit 25 is dropped; addresses wrap in 26 bits.
// - Program counter bit 0 is always zero.
// - Register numbers 0-5 and 16-20 select the documented system registers.
// - Numbers 6-15 and 21-31 are reserved; accesses there are unsupported.
// - Source register readable by store instruction, never written by load instruction.
// - Debug save pair accessible only between debug trap or illegal opcode and debug return.
// - Return ignores bit 0 of any saved program counter copy.
// - Exception or maskable interrupt saves counter and status to maskable pair, unless an NMI comes in the same cycle.
// - Saved counter is normally the next instruction address from the pipeline.
// - NMI saves counter and status to NMI pair, maskable pair untouched.
// - NMI saved counter is normally the next instruction address.
// - Maskable pair reserved bits (counter 31..26, status 31..8) read zero.
// - NMI pair reserved bits (counter 31..26, status 31..8) read zero.
// - Return after maskable servicing reloads counter and status from maskable pair.
// - Return after NMI servicing reloads counter and status from NMI pair.
// - Source register captures codes: NMI upper half, exception or maskable interrupt lower; resets zero.
// - Status load takes effect after the instruction; acknowledge held while writing.
package cesr_pkg;
  localparam int CESR_PC_BITS = 26;
  localparam int CESR_SW_BITS = 8;
  localparam logic [4:0] CESR_NUM_MASK_PC = 5'h00;
  localparam logic [4:0] CESR_NUM_MASK_SW = 5'h01;
  localparam logic [4:0] CESR_NUM_NMI_PC = 5'h02;
  localparam logic [4:0] CESR_NUM_NMI_SW = 5'h03;
  localparam logic [4:0] CESR_NUM_SOURCE = 5'h04;
  localparam logic [4:0] CESR_NUM_STATUS = 5'h05;
  localparam logic [4:0] CESR_NUM_CT_PC = 5'h10;
  localparam logic [4:0] CESR_NUM_CT_SW = 5'h11;
  localparam logic [4:0] CESR_NUM_DBG_PC = 5'h12;
  localparam logic [4:0] CESR_NUM_DBG_SW = 5'h13;
  localparam logic [4:0] CESR_NUM_CT_BASE = 5'h14;
  localparam int CESR_NP_BIT = 7;
  localparam int CESR_EP_BIT = 6;
  localparam int CESR_ID_BIT = 5;
  localparam logic [7:0] CESR_STATUS_RESET = 8'h20;
  localparam logic [31:0] CESR_SOURCE_RESET = 32'h0000_0000;
  localparam logic [25:0] CESR_PC_RESET = 26'h000_0000;
  localparam logic [31:0] CESR_WORD_RESET = 32'h0000_0000;
endpackage

// ---- dv/cesr_core_checker.sv ----
// Port checker for cesr_core.
// Assumes binding to cesr_core; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module cesr_core_checker
  import cesr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pc_load_i,
  input wire logic [31:0] pc_load_val_i,
  input wire logic pc_add_i,
  input wire logic [31:0] pc_add_val_i,
  input wire logic load_system_register_instr_i,
  input wire logic store_system_register_instr_i,
  input wire logic [4:0] sysreg_num_i,
  input wire logic [31:0] sysreg_wdata_i,
  input wire logic [31:0] sysreg_rdata_o,
  input wire logic sysreg_unsupported_o,
  input wire logic exception_i,
  input wire logic maskable_irq_i,
  input wire logic nmi_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic irq_ack_hold_o,
  input wire logic [31:0] pc_o,
  input wire logic [31:0] program_status_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ld, st, ret, ev;
  assign ld = load_system_register_instr_i;
  assign st = store_system_register_instr_i;
  assign ret = return_from_interrupt_instr_i;
  // NMI, exception, maskable interrupt or return outranks a status load
  assign ev = nmi_i | exception_i | maskable_irq_i | ret;
  chk_pc_upper: assert property (pc_o[31:26] == 6'h00)
    else $error("pc upper bits set");
  chk_pc_wrap: assert property (pc_add_i && !pc_load_i && !ret && !pc_add_val_i[0] |=>
    pc_o[25:0] == $past(pc_o[25:0]) + $past(pc_add_val_i[25:0])) else $error("pc add wrong");
  chk_pc_load: assert property (pc_load_i && !ret |=>
    pc_o == {6'h00, $past(pc_load_val_i[25:1]), 1'b0}) else $error("pc load wrong");
  chk_psw_load: assert property (ld && sysreg_num_i == CESR_NUM_STATUS && !ev |=>
    program_status_word_o == {24'h000000, $past(sysreg_wdata_i[7:0])}) else $error("status load wrong");
  chk_ack_hold: assert property (ld && sysreg_num_i == CESR_NUM_STATUS |-> irq_ack_hold_o)
    else $error("ack not held");
  chk_source_ro: assert property (ld && sysreg_num_i == CESR_NUM_SOURCE |-> sysreg_unsupported_o)
    else $error("source load accepted");
  chk_reserved_num: assert property ((ld || st) && sysreg_num_i inside {[6:15], [21:31]} |->
    sysreg_unsupported_o) else $error("reserved number accepted");
  chk_mask_rsv: assert property (st && sysreg_num_i == CESR_NUM_MASK_PC |-> sysreg_rdata_o[31:26] == 6'h00
    ##1 !st || sysreg_num_i != CESR_NUM_MASK_SW || sysreg_rdata_o[31:8] == 24'h000000) else $error("mask pair rsv");
  chk_nmi_rsv: assert property (st && sysreg_num_i == CESR_NUM_NMI_SW |->
    sysreg_rdata_o[31:8] == 24'h000000) else $error("nmi pair rsv");
endmodule
bind cesr_core cesr_core_checker chk (.*);
`default_nettype wire

// ---- dv/cesr_core_tb.sv ----
// Bench for cesr_core: register access, events, returns.
// Assumes the pipeline model supplies maskable interrupts.
`timescale 1ns/10ps
`default_nettype none
module cesr_core_tb;
  import cesr_pkg::*;
  localparam logic [15:0] MC = 16'h0031;
  logic clk_i = 1'b0, rst_i = 1'b1, pc_load_i = 1'b0, pc_add_i = 1'b0, mreq = 1'b0;
  logic load_system_register_instr_i = 1'b0, store_system_register_instr_i = 1'b0;
  logic maskable_irq_i, irq_ack_hold_o, sysreg_unsupported_o;
  logic [6:0] evt = 7'h00;
  logic [4:0] sysreg_num_i = 5'h00;
  logic [15:0] nmi_cause_code_i = 16'h0000, maskable_cause_code_i;
  logic [31:0] pc_load_val_i = '0, pc_add_val_i = '0, next_pc_i = '0, sysreg_wdata_i = '0;
  logic [31:0] sysreg_rdata_o, pc_o, program_status_word_o;
  logic [4:0] nums[5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05};
  logic [31:0] masks[5] = '{32'h03ff_ffff, 32'h0000_00ff, 32'h03ff_ffff, 32'h0000_00ff, 32'h0000_00ff};
  logic [4:0] rsv[4] = '{5'h06, 5'h0f, 5'h15, 5'h1f};
  int error_cnt = 0, checks = 0, i;
  always #5 clk_i = ~clk_i;
  cesr_core uut (.exception_i(evt[4]), .illegal_opcode_i(evt[5]), .table_call_instr_i(evt[6]), .nmi_i(evt[0]),
    .return_from_interrupt_instr_i(evt[1]), .debug_trap_instr_i(evt[2]), .debug_return_instr_i(evt[3]), .*);
  cesr_pipe_model #(.CODE(MC)) pm (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .hold_i(irq_ack_hold_o),
    .irq_o(maskable_irq_i), .code_o(maskable_cause_code_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] n, input logic [31:0] v, input logic r = 1'b0);
    step();
    load_system_register_instr_i <= 1'b1;
    sysreg_num_i <= n;
    sysreg_wdata_i <= v;
    mreq <= r;
    step();
    load_system_register_instr_i <= 1'b0;
    mreq <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] n, input logic [31:0] v, input logic u);
    step();
    store_system_register_instr_i <= 1'b1;
    sysreg_num_i <= n;
    #1;
    chk(sysreg_rdata_o, v);
    chk({31'h0, sysreg_unsupported_o}, {31'h0, u});
    step();
    store_system_register_instr_i <= 1'b0;
  endtask
  task automatic pulse(input int k);
    step();
    evt[k] <= 1'b1;
    step();
    evt[k] <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    step(12);
    rst_i <= 1'b0;
    rd(CESR_NUM_SOURCE, 32'h0000_0000, 1'b0); // source clear
    chk(program_status_word_o, 32'h0000_0020); // status reset
    $display("test reset done");
    pc_load_i <= 1'b1;
    pc_load_val_i <= 32'hffff_ffff;
    step();
    pc_load_i <= 1'b0;
    pc_add_i <= 1'b1;
    pc_add_val_i <= 32'h0000_0004;
    #1 chk(pc_o, 32'h03ff_fffe); // odd target
    step();
    pc_add_i <= 1'b0;
    #1 chk(pc_o, 32'h0000_0002); // carry dropped
    $display("test pc done");
    for (i = 0; i < 5; i++) begin
      wr(nums[i], 32'hffff_ffff);
      rd(nums[i], masks[i], 1'b0); // reserved zero
    end
    wr(CESR_NUM_SOURCE, 32'hffff_ffff);
    rd(CESR_NUM_SOURCE, 32'h0000_0000, 1'b0); // load ignored
    foreach (rsv[j]) rd(rsv[j], 32'h0000_0000, 1'b1); // unused numbers
    $display("test registers done");
    rd(CESR_NUM_DBG_PC, 32'h0000_0000, 1'b1); // closed window
    pulse(2);
    wr(CESR_NUM_DBG_PC, 32'h0000_0100);
    rd(CESR_NUM_DBG_PC, 32'h0000_0100, 1'b0); // open window
    pulse(3);
    rd(CESR_NUM_DBG_PC, 32'h0000_0000, 1'b1); // closed again
    $display("test debug done");
    next_pc_i <= 32'h0000_0104;
    wr(CESR_NUM_STATUS, 32'h0000_0000, 1'b1);
    #1;
    for (i = 0; i < 8 && maskable_irq_i !== 1'b1; i++) begin
      step();
      #1;
    end
    if (i == 8) begin
      error_cnt++;
      close_out();
    end
    chk(32'(i), 32'h0000_0001); // ack held
    rd(CESR_NUM_MASK_PC, 32'h0000_0104, 1'b0);
    rd(CESR_NUM_MASK_SW, 32'h0000_0000, 1'b0); // status saved
    rd(CESR_NUM_SOURCE, {16'h0000, MC}, 1'b0); // low half
    $display("test maskable done");
    nmi_cause_code_i <= 16'hbeef;
    next_pc_i <= 32'h0000_0200;
    pulse(0);
    rd(CESR_NUM_NMI_PC, 32'h0000_0200, 1'b0); // next address
    rd(CESR_NUM_NMI_SW, 32'h0000_0020, 1'b0); // status saved
    rd(CESR_NUM_MASK_PC, 32'h0000_0104, 1'b0); // pair untouched
    rd(CESR_NUM_SOURCE, {16'hbeef, MC}, 1'b0); // halves kept
    $display("test nmi done");
    wr(CESR_NUM_MASK_PC, 32'h0000_0105); // odd on purpose
    pulse(1);
    #1 chk(pc_o, 32'h0000_0200); // nmi pair
    chk(program_status_word_o, 32'h0000_0020); // status back
    pulse(1);
    #1 chk(pc_o, 32'h0000_0104); // bit ignored
    chk(program_status_word_o, 32'h0000_0000); // status back
    $display("test return done");
    rd(CESR_NUM_MASK_SW, 32'h0000_0000, 1'b0); // pair kept after return
    pulse(4);
    #1 chk(program_status_word_o, 32'h0000_0060); // exception flags set
    rd(CESR_NUM_MASK_PC, 32'h0000_0200, 1'b0); // exception save
    rd(CESR_NUM_MASK_SW, 32'h0000_0000, 1'b0); // status saved
    rd(CESR_NUM_SOURCE, {16'hbeef, ~MC}, 1'b0); // idle code low half
    pulse(5);
    rd(CESR_NUM_DBG_PC, 32'h0000_0200, 1'b0); // illegal opcode opens window
    pulse(3);
    rd(CESR_NUM_DBG_SW, 32'h0000_0000, 1'b1); // closed again
    pulse(6);
    rd(CESR_NUM_CT_PC, 32'h0000_0200, 1'b0); // table call save
    rd(CESR_NUM_CT_SW, 32'h0000_0060, 1'b0); // table call status
    $display("test exception done");
    close_out();
  end
endmodule
`default_nettype wire

// ---- dv/cesr_pipe_model.sv ----
// Pipeline model: one maskable interrupt per request.
// Assumes requests arrive on the CPU clock.
`timescale 1ns/10ps
`default_nettype none
module cesr_pipe_model #(
  parameter logic [15:0] CODE = 16'h0031
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic hold_i,
  output logic irq_o,
  output logic [15:0] code_o
);
  logic pend_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_o <= (pend_q || req_i) && !hold_i && !irq_o;
      pend_q <= (pend_q || req_i) && (hold_i || irq_o);
    end
  end
  // Idle code is inverted, never left stale
  assign code_o = irq_o ? CODE : ~CODE;
endmodule
`default_nettype wire

// ---- verilog/cesr_core.sv ----
// Exception-state registers: program counter, save pairs, source, status and system register file.
// Assumes the pipeline presents one request per cycle on clk_i, all from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module cesr_core
  import cesr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Program counter update from the pipeline
  input wire logic pc_load_i,
  input wire logic [31:0] pc_load_val_i,
  input wire logic pc_add_i,
  input wire logic [31:0] pc_add_val_i,
  input wire logic [31:0] next_pc_i,
  // System register access
  input wire logic load_system_register_instr_i,
  input wire logic store_system_register_instr_i,
  input wire logic [4:0] sysreg_num_i,
  input wire logic [31:0] sysreg_wdata_i,
  output logic [31:0] sysreg_rdata_o,
  output logic sysreg_unsupported_o,
  // Events
  input wire logic exception_i,
  input wire logic maskable_irq_i,
  input wire logic [15:0] maskable_cause_code_i,
  input wire logic nmi_i,
  input wire logic [15:0] nmi_cause_code_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic debug_trap_instr_i,
  input wire logic illegal_opcode_i,
  input wire logic debug_return_instr_i,
  input wire logic table_call_instr_i,
  output logic irq_ack_hold_o,
  output logic [31:0] pc_o,
  output logic [31:0] program_status_word_o
);
  logic [25:0] pc_q;
  logic [25:0] pc_d;
  logic [7:0] psw_q;
  logic [7:0] psw_d;
  logic [25:0] maskable_saved_pc_q;
  logic [7:0] maskable_saved_status_q;
  logic [25:0] nmi_saved_pc_q;
  logic [7:0] nmi_saved_status_q;
  logic [31:0] exception_source_q;
  logic [31:0] table_call_saved_pc_q;
  logic [31:0] table_call_saved_status_q;
  logic [31:0] debug_saved_pc_q;
  logic [31:0] debug_saved_status_q;
  logic [31:0] table_call_base_q;
  logic debug_mode_q;
  logic wr;
  logic mask_evt;
  logic dbg_ok;
  logic ret_nmi;

  assign wr = load_system_register_instr_i;
  assign dbg_ok = debug_mode_q;
  assign ret_nmi = psw_q[CESR_NP_BIT];
  assign mask_evt = (exception_i | maskable_irq_i) & ~nmi_i;

  assign irq_ack_hold_o = wr && (sysreg_num_i == CESR_NUM_STATUS);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      debug_mode_q <= 1'b0;
    end else if (debug_trap_instr_i || illegal_opcode_i) begin
      debug_mode_q <= 1'b1;
    end else if (debug_return_instr_i) begin
      debug_mode_q <= 1'b0;
    end
  end

  // Program counter next value
  always_comb begin
    pc_d = pc_q;
    if (return_from_interrupt_instr_i) begin
      pc_d = ret_nmi ? {nmi_saved_pc_q[25:1], 1'b0} : {maskable_saved_pc_q[25:1], 1'b0};
    end else if (pc_load_i) begin
      pc_d = pc_load_val_i[25:0];
    end else if (pc_add_i) begin
      // carry out of bit 25 dropped
      pc_d = pc_q + pc_add_val_i[25:0];
    end
    pc_d[0] = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= CESR_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  assign pc_o = {{(32 - CESR_PC_BITS){1'b0}}, pc_q};

  // Status word next value; bits above NP read zero
  always_comb begin
    psw_d = psw_q;
    if (return_from_interrupt_instr_i) begin
      psw_d = ret_nmi ? nmi_saved_status_q : maskable_saved_status_q;
    end else if (nmi_i) begin
      psw_d[CESR_NP_BIT] = 1'b1;
      psw_d[CESR_ID_BIT] = 1'b1;
    end else if (mask_evt) begin
      psw_d[CESR_ID_BIT] = 1'b1;
      if (exception_i) begin
        psw_d[CESR_EP_BIT] = 1'b1;
      end
    end else if (wr && sysreg_num_i == CESR_NUM_STATUS) begin
      psw_d = sysreg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psw_q <= CESR_STATUS_RESET;
    end else begin
      psw_q <= psw_d;
    end
  end

  assign program_status_word_o = {{(32 - CESR_SW_BITS){1'b0}}, psw_q};

  // Maskable save pair
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      maskable_saved_pc_q <= CESR_PC_RESET;
      maskable_saved_status_q <= CESR_STATUS_RESET;
    end else if (mask_evt) begin
      maskable_saved_pc_q <= {next_pc_i[25:1], 1'b0};
      maskable_saved_status_q <= psw_q;
    end else if (wr && sysreg_num_i == CESR_NUM_MASK_PC) begin
      maskable_saved_pc_q <= sysreg_wdata_i[25:0];
    end else if (wr && sysreg_num_i == CESR_NUM_MASK_SW) begin
      maskable_saved_status_q <= sysreg_wdata_i[7:0];
    end
  end

  // NMI save pair
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_saved_pc_q <= CESR_PC_RESET;
      nmi_saved_status_q <= CESR_STATUS_RESET;
    end else if (nmi_i) begin
      nmi_saved_pc_q <= {next_pc_i[25:1], 1'b0};
      nmi_saved_status_q <= psw_q;
    end else if (wr && sysreg_num_i == CESR_NUM_NMI_PC) begin
      nmi_saved_pc_q <= sysreg_wdata_i[25:0];
    end else if (wr && sysreg_num_i == CESR_NUM_NMI_SW) begin
      nmi_saved_status_q <= sysreg_wdata_i[7:0];
    end
  end

  // Source register; no load path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exception_source_q <= CESR_SOURCE_RESET;
    end else if (nmi_i) begin
      exception_source_q[31:16] <= nmi_cause_code_i;
    end else if (mask_evt) begin
      exception_source_q[15:0] <= maskable_cause_code_i;
    end
  end

  // Table call and debug registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_call_saved_pc_q <= CESR_WORD_RESET;
      table_call_saved_status_q <= CESR_WORD_RESET;
      table_call_base_q <= CESR_WORD_RESET;
    end else if (table_call_instr_i) begin
      table_call_saved_pc_q <= {6'h00, next_pc_i[25:1], 1'b0};
      table_call_saved_status_q <= {24'h000000, psw_q};
    end else if (wr) begin
      case (sysreg_num_i)
        CESR_NUM_CT_PC: table_call_saved_pc_q <= sysreg_wdata_i;
        CESR_NUM_CT_SW: table_call_saved_status_q <= sysreg_wdata_i;
        CESR_NUM_CT_BASE: table_call_base_q <= sysreg_wdata_i;
        default: table_call_base_q <= table_call_base_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      debug_saved_pc_q <= CESR_WORD_RESET;
      debug_saved_status_q <= CESR_WORD_RESET;
    end else if (debug_trap_instr_i || illegal_opcode_i) begin
      debug_saved_pc_q <= {6'h00, next_pc_i[25:1], 1'b0};
      debug_saved_status_q <= {24'h000000, psw_q};
    end else if (wr && dbg_ok && sysreg_num_i == CESR_NUM_DBG_PC) begin
      debug_saved_pc_q <= sysreg_wdata_i;
    end else if (wr && dbg_ok && sysreg_num_i == CESR_NUM_DBG_SW) begin
      debug_saved_status_q <= sysreg_wdata_i;
    end
  end

  always_comb begin
    sysreg_rdata_o = 32'h0000_0000;
    sysreg_unsupported_o = 1'b0;
    case (sysreg_num_i)
      CESR_NUM_MASK_PC: sysreg_rdata_o = {6'h00, maskable_saved_pc_q};
      CESR_NUM_MASK_SW: sysreg_rdata_o = {24'h000000, maskable_saved_status_q};
      CESR_NUM_NMI_PC: sysreg_rdata_o = {6'h00, nmi_saved_pc_q};
      CESR_NUM_NMI_SW: sysreg_rdata_o = {24'h000000, nmi_saved_status_q};
      CESR_NUM_SOURCE: begin
        sysreg_rdata_o = exception_source_q;
        sysreg_unsupported_o = wr;
      end
      CESR_NUM_STATUS: sysreg_rdata_o = {24'h000000, psw_q};
      CESR_NUM_CT_PC: sysreg_rdata_o = table_call_saved_pc_q;
      CESR_NUM_CT_SW: sysreg_rdata_o = table_call_saved_status_q;
      CESR_NUM_DBG_PC: begin
        sysreg_rdata_o = dbg_ok ? debug_saved_pc_q : 32'h0000_0000;
        sysreg_unsupported_o = ~dbg_ok & (wr | store_system_register_instr_i);
      end
      CESR_NUM_DBG_SW: begin
        sysreg_rdata_o = dbg_ok ? debug_saved_status_q : 32'h0000_0000;
        sysreg_unsupported_o = ~dbg_ok & (wr | store_system_register_instr_i);
      end
      CESR_NUM_CT_BASE: sysreg_rdata_o = table_call_base_q;
      default: sysreg_unsupported_o = wr | store_system_register_instr_i;
    endcase
  end
endmodule
`default_nettype wire
